/* File: octal_switch_pkg.sv */
// Purpose: Shared constants and types for the octal switch control block
// Assumes: 50 MHz system clock
// Notes:   Behaviour list below
//
// Behaviour
// - Gate low holds all outputs off
// - Gate falling edge turns outputs off
// - Outputs re-enable only after gate high
// - Capture low, transfer high: store inputs
// - Capture high, transfer low: copy buffer, suspend refresh
// - All high: outputs left unchanged
// - Periodic refresh reapplies stored configuration
// - Channel n input drives output n
// - Direct mode strobe high keeps outputs
// - Direct mode strobe low: inputs drive outputs
// - Strobes tied low: outputs follow inputs
// - Watchdog timeout turns all outputs off
// - Refresh counts as valid watchdog update
// - Watchdog timeout nominal 320 us
// - Transfer rising edge updates outputs
package octal_switch_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int CHANNELS = 8;

  // Update timeout in microseconds, nominal
  localparam int UPDATE_TIMEOUT_US = 320;
  localparam int UPDATE_TIMEOUT_CYCLES = UPDATE_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // Refresh rate in hertz
  localparam int REFRESH_HZ = 15_000;
  localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;

  localparam logic [CHANNELS-1:0] CHAN_RESET = 8'h00;

  typedef struct packed {
    logic captureN;
    logic transferN;
    logic gate;
  } ctrl_t;

  // Idle pin levels: both strobes released, gate high
  localparam ctrl_t CTRL_IDLE = 3'h7;

endpackage : octal_switch_pkg

/* File: sync_stage.sv */
// Purpose: Two-flop synchroniser for a bus of asynchronous levels
// Assumes: Inputs change slowly relative to clk
// Notes:   First stage read only by second stage
`timescale 1ns/1ps
module sync_stage #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      synced <= INIT;
    end else begin
      meta_q <= meta_d;
      synced <= sync_d;
    end
  end

endmodule : sync_stage

/* File: octal_switch_ctrl.sv */
// Purpose: Control front end for an isolated eight-channel output switch
// Assumes: All control and channel inputs are asynchronous pins
// Notes:   Outputs registered; timeout is a parameter for simulation
`timescale 1ns/1ps
module octal_switch_ctrl
  import octal_switch_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = UPDATE_TIMEOUT_CYCLES,
  parameter int REFRESH_PERIOD = REFRESH_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [CHANNELS-1:0] channelInput,
  input  wire logic                captureN,
  input  wire logic                transferN,
  input  wire logic                outputGate,
  output logic      [CHANNELS-1:0] channelOutput,
  output logic                     refreshSuspended,
  output logic                     timeoutActive
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  ctrl_t               ctrlS;
  logic [CHANNELS-1:0] inS;

  // Reset to idle levels so no false strobe edge follows reset
  sync_stage #(.WIDTH(3), .INIT(CTRL_IDLE)) u_ctrl_sync (
    .clk    (clk),
    .rst    (rst),
    .async  ({captureN, transferN, outputGate}),
    .synced (ctrlS)
  );

  sync_stage #(.WIDTH(CHANNELS)) u_in_sync (
    .clk    (clk),
    .rst    (rst),
    .async  (channelInput),
    .synced (inS)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] count_next(input logic [31:0] c,
                                             input logic [31:0] lim);
    count_next = (c >= lim - 32'd1) ? 32'd0 : c + 32'd1;
  endfunction : count_next

  logic  xferPrev_q;
  logic  gatePrev_q;
  logic  capture;
  logic  transfer;
  logic  direct;
  logic  xferRise;
  logic  gateFall;

  always_comb begin
    capture  = !ctrlS.captureN && ctrlS.transferN;
    transfer = ctrlS.captureN && !ctrlS.transferN;
    direct   = !ctrlS.captureN && !ctrlS.transferN;
    xferRise = ctrlS.captureN && ctrlS.transferN && !xferPrev_q;
    gateFall = gatePrev_q && !ctrlS.gate;
  end

  // ----------------------------------------------------------------
  // Buffers, refresh and watchdog
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] inBuf_q, inBuf_d;
  logic [CHANNELS-1:0] txBuf_q, txBuf_d;
  logic [CHANNELS-1:0] applied_q, applied_d;
  logic [CHANNELS-1:0] out_d;
  logic [31:0]         refCnt_q, refCnt_d;
  logic [31:0]         wdCnt_q, wdCnt_d;
  logic                timeout_d;
  logic                refreshTick;
  logic                update;

  always_comb begin
    inBuf_d   = inBuf_q;
    txBuf_d   = txBuf_q;
    applied_d = applied_q;
    update    = 1'b0;
    if (capture) begin
      inBuf_d = inS;
    end
    if (transfer) begin
      txBuf_d = inBuf_q;
    end
    // Refresh runs unless suspended by transfer strobe
    refCnt_d    = transfer ? 32'd0 : count_next(refCnt_q,
                                     32'(REFRESH_PERIOD));
    refreshTick = !transfer && (refCnt_q == 32'(REFRESH_PERIOD) - 32'd1);
    if (direct) begin
      applied_d = inS;
      txBuf_d   = inS;
      inBuf_d   = inS;
      update    = 1'b1;
    end else if (xferRise) begin
      applied_d = txBuf_q;
      update    = 1'b1;
    end
    if (refreshTick) begin
      update = 1'b1;
    end
    // Watchdog: reload on any update, latch off at expiry
    if (update) begin
      wdCnt_d   = 32'd0;
      timeout_d = 1'b0;
    end else if (wdCnt_q >= 32'(TIMEOUT_CYCLES) - 32'd1) begin
      wdCnt_d   = wdCnt_q;
      timeout_d = 1'b1;
    end else begin
      wdCnt_d   = wdCnt_q + 32'd1;
      timeout_d = timeoutActive;
    end
    // Gate low, gate fall or timeout forces all off; otherwise applied value drives
    if (!ctrlS.gate || gateFall || timeout_d) begin
      out_d = '0;
    end else begin
      out_d = applied_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inBuf_q          <= CHAN_RESET;
      txBuf_q          <= CHAN_RESET;
      applied_q        <= CHAN_RESET;
      channelOutput    <= CHAN_RESET;
      refCnt_q         <= 32'd0;
      wdCnt_q          <= 32'd0;
      timeoutActive    <= 1'b0;
      refreshSuspended <= 1'b0;
      xferPrev_q       <= 1'b1;
      gatePrev_q       <= 1'b0;
    end else begin
      inBuf_q          <= inBuf_d;
      txBuf_q          <= txBuf_d;
      applied_q        <= applied_d;
      channelOutput    <= out_d;
      refCnt_q         <= refCnt_d;
      wdCnt_q          <= wdCnt_d;
      timeoutActive    <= timeout_d;
      refreshSuspended <= transfer;
      xferPrev_q       <= ctrlS.transferN;
      gatePrev_q       <= ctrlS.gate;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gate_low_off: assert property (
    @(posedge clk) disable iff (rst)
    !ctrlS.gate |=> channelOutput == '0)
    else $error("outputs on while gate low");

  a_gate_fall_off: assert property (
    @(posedge clk) disable iff (rst)
    $fell(ctrlS.gate) |=> channelOutput == '0)
    else $error("outputs not off after gate fall");

  a_gate_high_on: assert property (
    @(posedge clk) disable iff (rst)
    ctrlS.gate && gatePrev_q && !timeout_d |=> channelOutput == applied_q)
    else $error("outputs not restored with gate high");

  a_capture_store: assert property (
    @(posedge clk) disable iff (rst)
    capture |=> inBuf_q == $past(inS) && applied_q == $past(applied_q))
    else $error("capture did not store inputs");

  a_transfer_copy: assert property (
    @(posedge clk) disable iff (rst)
    transfer |=> txBuf_q == $past(inBuf_q) && refreshSuspended)
    else $error("transfer did not copy buffer");

  a_hold_idle: assert property (
    @(posedge clk) disable iff (rst)
    ctrlS.captureN && ctrlS.transferN && xferPrev_q
      |=> applied_q == $past(applied_q))
    else $error("idle changed outputs");

  a_direct_follow: assert property (
    @(posedge clk) disable iff (rst)
    direct && ctrlS.gate && gatePrev_q |=> channelOutput == $past(inS))
    else $error("direct mode output mismatch");

  a_xfer_update: assert property (
    @(posedge clk) disable iff (rst)
    xferRise |=> applied_q == $past(txBuf_q))
    else $error("transfer edge did not update");

  a_wd_expire: assert property (
    @(posedge clk) disable iff (rst)
    timeoutActive |-> channelOutput == '0 || $past(update))
    else $error("outputs on after timeout");

endmodule : octal_switch_ctrl

/* File: host_model.sv */
// Purpose: Host model driving the parallel control pins
// Assumes: Wanted levels change only on the falling clock edge
// Notes:   Direct mode ties both strobes to one common signal
`timescale 1ns/1ps
module host_model
  import octal_switch_pkg::*;
(
  input  wire logic                directMode,
  input  wire logic [CHANNELS-1:0] wantChan,
  input  wire ctrl_t               wantCtrl,
  output logic      [CHANNELS-1:0] chanIn,
  output ctrl_t                    ctrl
);
  always_comb begin
    chanIn = wantChan;
    ctrl   = wantCtrl;
    if (directMode) begin
      ctrl.transferN = wantCtrl.captureN;
    end
  end
endmodule : host_model

/* File: tb_octal_switch_parallel_control.sv */
// Purpose: Self-checking bench for the octal switch control block
// Assumes: Short watchdog and refresh counts for simulation
// Notes:   Host pins come from host_model; tasks set its wanted levels
`timescale 1ns/1ps
module tb_octal_switch_parallel_control
  import octal_switch_pkg::*;
;
  localparam int TMO = 200;
  localparam int REF = 50;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                directMode = 1'b0;
  logic [CHANNELS-1:0] wantChan = CHAN_RESET;
  ctrl_t               wantCtrl = CTRL_IDLE;
  logic [CHANNELS-1:0] chanIn;
  logic [CHANNELS-1:0] chanOut;
  ctrl_t               ctrl;
  logic                suspended;
  logic                expired;
  int                  errorCnt = 0;
  int                  nCompared = 0;
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin \
  errorCnt++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
  always #10 clk = ~clk;
  host_model host (
    .directMode (directMode),
    .wantChan   (wantChan),
    .wantCtrl   (wantCtrl),
    .chanIn     (chanIn),
    .ctrl       (ctrl));
  octal_switch_ctrl #(.TIMEOUT_CYCLES(TMO), .REFRESH_PERIOD(REF)) dut (
    .clk(clk), .rst(rst), .channelInput(chanIn),
    .captureN(ctrl.captureN), .transferN(ctrl.transferN),
    .outputGate(ctrl.gate), .channelOutput(chanOut),
    .refreshSuspended(suspended), .timeoutActive(expired));
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // Six-cycle strobe; inputs move only once the strobe is back up
  task automatic strobe(input logic dm, input logic [CHANNELS-1:0] v);
    @(negedge clk);
    directMode = dm;
    wantChan = v;
    wantCtrl.captureN = 1'b0;
    hold(6);
    wantCtrl.captureN = 1'b1;
    hold(1);
    wantChan = ~v;
  endtask : strobe
  task automatic setXfer(input logic lvl);
    @(negedge clk);
    wantCtrl.transferN = lvl;
  endtask : setXfer
  task automatic setGate(input logic lvl);
    @(negedge clk);
    wantCtrl.gate = lvl;
  endtask : setGate
  task automatic t_direct();
    strobe(1'b1, 8'ha5);
    `CHK("direct out", 8'ha5, chanOut)
    hold(8);
    `CHK("direct kept", 8'ha5, chanOut)
    $display("test direct done");
  endtask : t_direct
  task automatic t_staged();
    strobe(1'b0, 8'h3c);
    hold(4);
    `CHK("capture out", 8'ha5, chanOut)
    setXfer(1'b0);
    hold(6);
    `CHK("suspended", 1'b1, suspended)
    `CHK("copy out", 8'ha5, chanOut)
    setXfer(1'b1);
    hold(6);
    `CHK("apply out", 8'h3c, chanOut)
    `CHK("resumed", 1'b0, suspended)
    hold(10);
    `CHK("idle out", 8'h3c, chanOut)
    $display("test staged done");
  endtask : t_staged
  task automatic t_gate();
    setGate(1'b0);
    hold(5);
    `CHK("gate low out", 8'h00, chanOut)
    setGate(1'b1);
    hold(5);
    `CHK("gate high out", 8'h3c, chanOut)
    $display("test gate done");
  endtask : t_gate
  task automatic t_watchdog();
    int i;
    hold(2 * TMO);
    `CHK("refresh feeds", 1'b0, expired)
    strobe(1'b0, 8'h42);
    setXfer(1'b0);
    for (i = 0; i < 2 * TMO && expired !== 1'b1; i++) hold(1);
    `CHK("expired", 1'b1, expired)
    if (expired !== 1'b1) conclude();
    `CHK("expiry time", 1'b1, (i >= TMO - REF) && (i <= TMO + 3))
    `CHK("expired out", 8'h00, chanOut)
    setXfer(1'b1);
    hold(6);
    `CHK("revived", 1'b0, expired)
    `CHK("revived out", 8'h42, chanOut)
    $display("test watchdog done");
  endtask : t_watchdog
  // Strobes held low together: outputs follow inputs except gate low
  task automatic t_tied();
    @(negedge clk);
    directMode = 1'b1;
    wantCtrl.captureN = 1'b0;
    wantChan = 8'h81;
    hold(4);
    `CHK("tied out", 8'h81, chanOut)
    wantChan = 8'h18;
    hold(4);
    `CHK("tied follow", 8'h18, chanOut)
    wantCtrl.gate = 1'b0;
    hold(4);
    `CHK("tied gate low", 8'h00, chanOut)
    wantCtrl.gate = 1'b1;
    hold(4);
    `CHK("tied gate high", 8'h18, chanOut)
    wantCtrl.captureN = 1'b1;
    hold(1);
    wantChan = 8'hff;
    hold(4);
    `CHK("tied released", 8'h18, chanOut)
    $display("test tied done");
  endtask : t_tied
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_direct();
    t_staged();
    t_gate();
    t_watchdog();
    t_tied();
    conclude();
  end
endmodule : tb_octal_switch_parallel_control
